// ---- hw/swc_wake_ctrl.sv ----
`timescale 1ns/10ps
`default_nettype none
module swc_wake_ctrl
  import swc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic sleeping,
  input wire logic tick_62ms,
  input wire logic wake_pin_p03,
  input wire logic wake_pin_p02,
  input wire logic energy_pulse_output,
  output logic wake_resume,
  output logic wake_reset,
  output logic clear_sleep_ctl
);
  swc_state_s st;
  swc_state_s next_st;
  logic rtc_evt;
  logic [SWC_CNT_W-1:0] limit;
  logic hit_p03;
  logic hit_p02;
  logic io_evt;
  logic pulse_evt;
  logic sleep_entry;

  // Active-edge test; 00 and 11 both mean falling
  function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
    case (sel)
      SWC_EDGE_RISE: edge_hit = !prev && cur;
      SWC_EDGE_BOTH: edge_hit = prev != cur;
      default: edge_hit = prev && !cur;
    endcase
  endfunction : edge_hit

  // Interval length in base ticks for the programmed mode
  function automatic logic [SWC_CNT_W-1:0] interval_ticks(input logic [7:0] rtc_iv,
                                                          input logic [7:0] sec_iv);
    if (sec_iv[SWC_SEC_MODE_BIT]) begin
      if (sec_iv[5:0] == 6'h00) begin
        interval_ticks = SWC_TICKS_62MS;
      end else begin
        interval_ticks = SWC_CNT_W'({sec_iv[5:0], 4'h0} + SWC_TICKS_1S);
      end
    end else begin
      case (rtc_iv[2:0])
        3'h0: interval_ticks = SWC_TICKS_1S;
        3'h1: interval_ticks = SWC_TICKS_1MIN;
        3'h2: interval_ticks = SWC_TICKS_1H;
        3'h3: interval_ticks = SWC_TICKS_1DAY;
        3'h4: interval_ticks = SWC_TICKS_500MS;
        3'h5: interval_ticks = SWC_TICKS_250MS;
        3'h6: interval_ticks = SWC_TICKS_125MS;
        default: interval_ticks = SWC_TICKS_62MS;
      endcase
    end
  endfunction : interval_ticks

  // Seconds mode trusts software to have loaded 0x07 first; no check is made here
  assign limit = interval_ticks(st.rtc_iv, st.sec_iv);

  // RTC events only while sleeping, once per interval
  swc_interval_timer u_timer (
    .clock(clock),
    .rst_n(rst_n),
    .run(sleeping),
    .tick(tick_62ms),
    .limit(limit),
    .event_out(rtc_evt)
  );

  // Wake sources, all qualified by the sleep state
  assign hit_p03 = edge_hit(st.edge_sel[7:6], st.prev_p03, wake_pin_p03);
  assign hit_p02 = edge_hit(st.edge_sel[5:4], st.prev_p02, wake_pin_p02);
  assign io_evt = sleeping && st.io_ctl[SWC_CTL_PORT0_EN] && (hit_p03 || hit_p02);
  assign pulse_evt = sleeping && st.io_ctl[SWC_CTL_PULSE_EN] && energy_pulse_output;
  assign sleep_entry = sleeping && !st.prev_sleep;

  // Next-state logic: bus writes, wake decisions, sticky status flags
  always_comb begin
    next_st = st;
    next_st.prev_p03 = wake_pin_p03;
    next_st.prev_p02 = wake_pin_p02;
    next_st.prev_sleep = sleeping;
    if (sfr_wr) begin
      case (sfr_addr)
        SWC_RTC_IV_ADDR: next_st.rtc_iv = sfr_wdata;
        SWC_IO_CTL_ADDR: next_st.io_ctl = sfr_wdata[2:0];
        SWC_SEC_IV_ADDR: next_st.sec_iv = sfr_wdata;
        SWC_EDGE_SEL_ADDR: next_st.edge_sel = sfr_wdata;
        default: next_st.io_ctl = st.io_ctl;
      endcase
    end
    // Wake requests; a pin resume also clears sleep and power-control bits elsewhere
    next_st.wake_resume = (io_evt && st.io_ctl[SWC_CTL_NO_RESET]) || pulse_evt
                          || (rtc_evt && sleeping);
    next_st.clear_sleep_ctl = io_evt && st.io_ctl[SWC_CTL_NO_RESET];
    next_st.wake_reset = io_evt && !st.io_ctl[SWC_CTL_NO_RESET];
    // Flags clear on entry to sleep; a same-cycle set still wins
    if (sleep_entry) begin
      next_st.io_flag = 1'b0;
      next_st.rtc_flag = 1'b0;
      next_st.pulse_flag = 1'b0;
      next_st.p03_flag = 1'b0;
      next_st.p02_flag = 1'b0;
    end
    if (io_evt) begin
      next_st.io_flag = 1'b1;
      // Build on next_st so a clear on sleep entry in this cycle is kept
      next_st.p03_flag = next_st.p03_flag || hit_p03;
      next_st.p02_flag = next_st.p02_flag || hit_p02;
    end
    if (pulse_evt) begin
      next_st.rtc_flag = 1'b1;
      next_st.pulse_flag = 1'b1;
    end else if (rtc_evt && sleeping) begin
      next_st.rtc_flag = 1'b1;
      next_st.pulse_flag = 1'b0;
    end
    // Registered read data, one cycle behind the address; reserved bits read zero
    case (sfr_addr)
      SWC_RTC_IV_ADDR: next_st.rdata = st.rtc_iv;
      SWC_IO_CTL_ADDR: next_st.rdata = {5'h00, st.io_ctl};
      SWC_SEC_IV_ADDR: next_st.rdata = st.sec_iv;
      SWC_EDGE_SEL_ADDR: next_st.rdata = st.edge_sel;
      SWC_SYS_STATE_ADDR: next_st.rdata = {4'h0, st.io_flag, st.rtc_flag, 2'h0};
      SWC_WAKE_FLAG_ADDR: next_st.rdata = {4'h0, st.pulse_flag, st.p03_flag, st.p02_flag, 1'b0};
      default: next_st.rdata = SWC_REG_RESET;
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Every output straight from the state register
  assign sfr_rdata = st.rdata;
  assign wake_resume = st.wake_resume;
  assign wake_reset = st.wake_reset;
  assign clear_sleep_ctl = st.clear_sleep_ctl;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  sequence s_pulse_wake;
    sleeping && st.io_ctl[SWC_CTL_PULSE_EN] && energy_pulse_output;
  endsequence
  sequence s_rise_p02;
    sleeping && st.io_ctl[SWC_CTL_PORT0_EN] && st.edge_sel[5:4] == SWC_EDGE_RISE
      && !st.prev_p02 && wake_pin_p02;
  endsequence
  sequence s_rtc_only;
    sleeping && rtc_evt && !pulse_evt && !sleep_entry;
  endsequence

  property p_pulse_wake;
    s_pulse_wake |=> wake_resume ##0 st.pulse_flag;
  endproperty
  a_pulse_wake: assert property (p_pulse_wake) else $error("pulse did not wake");

  property p_pulse_off;
    sleeping && !st.io_ctl[SWC_CTL_PULSE_EN] && !st.io_ctl[SWC_CTL_PORT0_EN] && !rtc_evt
      |=> !wake_resume;
  endproperty
  a_pulse_off: assert property (p_pulse_off) else $error("wake with sources off");

  property p_io_block;
    !st.io_ctl[SWC_CTL_PORT0_EN] |=> !wake_reset && !clear_sleep_ctl;
  endproperty
  a_io_block: assert property (p_io_block) else $error("pin wake while disabled");

  property p_resume;
    clear_sleep_ctl |-> wake_resume && !wake_reset && $past(st.io_ctl[SWC_CTL_NO_RESET]);
  endproperty
  a_resume: assert property (p_resume) else $error("resume wake wrong");

  property p_reset;
    wake_reset |-> !clear_sleep_ctl && st.io_flag && !$past(st.io_ctl[SWC_CTL_NO_RESET]);
  endproperty
  a_reset: assert property (p_reset) else $error("reset wake wrong");

  property p_iv_code;
    !st.sec_iv[SWC_SEC_MODE_BIT] && st.rtc_iv[2:0] == 3'h3 |-> limit == SWC_TICKS_1DAY;
  endproperty
  a_iv_code: assert property (p_iv_code) else $error("day interval wrong");

  property p_sec_iv;
    st.sec_iv[SWC_SEC_MODE_BIT] && st.sec_iv[5:0] != 6'h00
      |-> limit == (SWC_CNT_W'(st.sec_iv[5:0]) + 1'b1) * SWC_TICKS_1S;
  endproperty
  a_sec_iv: assert property (p_sec_iv) else $error("seconds interval wrong");

  property p_sec_zero;
    st.sec_iv[SWC_SEC_MODE_BIT] && st.sec_iv[5:0] == 6'h00 |-> limit == SWC_TICKS_62MS;
  endproperty
  a_sec_zero: assert property (p_sec_zero) else $error("zero interval wrong");

  property p_io_flag;
    wake_reset || clear_sleep_ctl |-> st.io_flag;
  endproperty
  a_io_flag: assert property (p_io_flag) else $error("io flag missing");

  property p_rtc_flag;
    s_rtc_only |=> st.rtc_flag && !st.pulse_flag && wake_resume;
  endproperty
  a_rtc_flag: assert property (p_rtc_flag) else $error("rtc flags wrong");

  property p_edge_rise;
    s_rise_p02 |=> (wake_reset || clear_sleep_ctl) && st.p02_flag;
  endproperty
  a_edge_rise: assert property (p_edge_rise) else $error("rising edge missed");

  property p_rtc_sleep;
    !sleeping |=> !rtc_evt;
  endproperty
  a_rtc_sleep: assert property (p_rtc_sleep) else $error("rtc event while awake");
endmodule : swc_wake_ctrl
`default_nettype wire

// ---- hw/swc_pkg.sv ----
package swc_pkg;
  // Register offsets on the special-function bus
  localparam logic [7:0] SWC_SYS_STATE_ADDR = 8'ha1;
  localparam logic [7:0] SWC_WAKE_FLAG_ADDR = 8'haf;
  localparam logic [7:0] SWC_EDGE_SEL_ADDR = 8'hc7;
  localparam logic [7:0] SWC_RTC_IV_ADDR = 8'h96;
  localparam logic [7:0] SWC_IO_CTL_ADDR = 8'hc9;
  localparam logic [7:0] SWC_SEC_IV_ADDR = 8'hdf;
  // Reset values
  localparam logic [7:0] SWC_REG_RESET = 8'h00;
  // Field positions in io_wake_control
  localparam int SWC_CTL_PULSE_EN = 2;
  localparam int SWC_CTL_PORT0_EN = 1;
  localparam int SWC_CTL_NO_RESET = 0;
  // Field positions in rtc_seconds_wake_interval
  localparam int SWC_SEC_MODE_BIT = 6;
  // Field positions in the status registers
  localparam int SWC_SYS_IO_BIT = 3;
  localparam int SWC_SYS_RTC_BIT = 2;
  localparam int SWC_FLG_PULSE_BIT = 3;
  localparam int SWC_FLG_P03_BIT = 2;
  localparam int SWC_FLG_P02_BIT = 1;
  // Edge select codes
  localparam logic [1:0] SWC_EDGE_RISE = 2'h1;
  localparam logic [1:0] SWC_EDGE_BOTH = 2'h2;
  // Interval lengths in 62.5 ms base ticks
  localparam int SWC_CNT_W = 21;
  localparam logic [20:0] SWC_TICKS_62MS = 21'h0_0001;
  localparam logic [20:0] SWC_TICKS_125MS = 21'h0_0002;
  localparam logic [20:0] SWC_TICKS_250MS = 21'h0_0004;
  localparam logic [20:0] SWC_TICKS_500MS = 21'h0_0008;
  localparam logic [20:0] SWC_TICKS_1S = 21'h0_0010;
  localparam logic [20:0] SWC_TICKS_1MIN = 21'h0_03c0;
  localparam logic [20:0] SWC_TICKS_1H = 21'h0_e100;
  localparam logic [20:0] SWC_TICKS_1DAY = 21'h15_1800;

  // Interval timer state
  typedef struct packed {
    logic [SWC_CNT_W-1:0] count;
    logic event_out;
  } swc_tmr_s;

  // Wakeup control state
  typedef struct packed {
    logic [7:0] rtc_iv;
    logic [2:0] io_ctl;
    logic [7:0] sec_iv;
    logic [7:0] edge_sel;
    logic prev_p03;
    logic prev_p02;
    logic prev_sleep;
    logic io_flag;
    logic rtc_flag;
    logic pulse_flag;
    logic p03_flag;
    logic p02_flag;
    logic wake_resume;
    logic wake_reset;
    logic clear_sleep_ctl;
    logic [7:0] rdata;
  } swc_state_s;
endpackage : swc_pkg

// ---- hw/swc_interval_timer.sv ----
`timescale 1ns/10ps
`default_nettype none
module swc_interval_timer
  import swc_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic tick,
  input wire logic [SWC_CNT_W-1:0] limit,
  output logic event_out
);
  swc_tmr_s st;
  swc_tmr_s next_st;

  // Count base ticks only while asleep; leaving sleep restarts the interval
  always_comb begin
    next_st = st;
    next_st.event_out = 1'b0;
    if (!run) begin
      next_st.count = '0;
    end else if (tick) begin
      if (st.count + 1'b1 >= limit) begin
        next_st.count = '0;
        next_st.event_out = 1'b1;
      end else begin
        next_st.count = st.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign event_out = st.event_out;
endmodule : swc_interval_timer
`default_nettype wire

// ---- bench/swc_wake_ctrl_test.sv ----
`timescale 1ns/10ps
`default_nettype none
module swc_wake_ctrl_test
  import swc_pkg::*;
;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic sfr_wr = 1'b0;
  logic sleeping = 1'b0;
  logic tick_62ms = 1'b0;
  logic wake_pin_p03 = 1'b0;
  logic wake_pin_p02 = 1'b0;
  logic energy_pulse_output = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic [7:0] sfr_wdata = 8'h00;
  logic [7:0] sfr_rdata;
  logic wake_resume;
  logic wake_reset;
  logic clear_sleep_ctl;
  logic [31:0] seed = 32'h0001_7cc3;
  logic [7:0] v;
  int miscompares = 0;
  int checks = 0;
  int n_res = 0;
  int n_rst = 0;
  int n_clr = 0;
  int hit;
  int lt;
  // Fixed intervals in 62.5 ms ticks, by code
  int tbl[8] = '{16, 960, 57600, 1382400, 8, 4, 2, 1};

  always #20 clock = ~clock;

  swc_wake_ctrl swc_wake_ctrl_i (
    .clock(clock),
    .rst_n(rst_n),
    .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata),
    .sfr_rdata(sfr_rdata),
    .sleeping(sleeping),
    .tick_62ms(tick_62ms),
    .wake_pin_p03(wake_pin_p03),
    .wake_pin_p02(wake_pin_p02),
    .energy_pulse_output(energy_pulse_output),
    .wake_resume(wake_resume),
    .wake_reset(wake_reset),
    .clear_sleep_ctl(clear_sleep_ctl)
  );

  // Outputs stand one cycle, so count them at every edge
  always @(posedge clock) begin
    if (wake_resume === 1'b1) n_res <= n_res + 1;
    if (wake_reset === 1'b1) n_rst <= n_rst + 1;
    if (clear_sleep_ctl === 1'b1) n_clr <= n_clr + 1;
  end

  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd

  // Seconds mode overrides the code; a zero count falls back to one tick
  function automatic int lim(logic [7:0] iv, logic [7:0] sv);
    if (sv[6]) return (sv[5:0] == 6'h00) ? 1 : (int'(sv[5:0]) + 1) * 16;
    return tbl[iv[2:0]];
  endfunction : lim

  task automatic end_of_test();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge clock);
    sfr_wr <= 1'b0;
  endtask : wr

  // Read data lags the sampled address by one edge
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clock);
    sfr_addr <= a;
    cyc(2);
    #1 chk($sformatf("reg %0h", a), e, sfr_rdata);
  endtask : rd

  // Leave sleep with pins settled, then re-enter so the flags start clear
  task automatic arm(input logic p3, input logic p2);
    @(posedge clock);
    sleeping <= 1'b0;
    wake_pin_p03 <= p3;
    wake_pin_p02 <= p2;
    cyc(3);
    sleeping <= 1'b1;
    cyc(2);
    @(negedge clock) {n_res, n_rst, n_clr} = '0;
  endtask : arm

  task automatic tick();
    @(posedge clock);
    tick_62ms <= 1'b1;
    @(posedge clock);
    tick_62ms <= 1'b0;
  endtask : tick

  // A hang is cut short well past the expected run length
  initial begin
    #(40 * 30000);
    miscompares++;
    end_of_test();
  end

  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    foreach (tbl[i]) rd(8'h96 ^ 8'(i * 91), 8'h00);
    rd(SWC_IO_CTL_ADDR, 8'h00);
    rd(SWC_SEC_IV_ADDR, 8'h00);
    repeat (4) begin
      v = rnd();
      wr(SWC_RTC_IV_ADDR, v);
      rd(SWC_RTC_IV_ADDR, v);
      wr(SWC_IO_CTL_ADDR, v);
      rd(SWC_IO_CTL_ADDR, v & 8'h07);
      wr(SWC_SEC_IV_ADDR, v);
      rd(SWC_SEC_IV_ADDR, v);
      wr(SWC_SYS_STATE_ADDR, v);
      rd(SWC_SYS_STATE_ADDR, 8'h00);
    end
    $display("Test registers done");
    wr(SWC_RTC_IV_ADDR, 8'h02);
    for (int c = 0; c < 16; c++) begin
      for (int p = 0; p < 4; p++) begin
        v = rnd();
        wr(SWC_IO_CTL_ADDR, {6'h00, c[3], v[0]});
        wr(SWC_EDGE_SEL_ADDR, {c[1:0], c[1:0], 4'h0});
        arm(p[1], p[1]);
        @(posedge clock);
        if (p[0]) wake_pin_p03 <= ~p[1];
        else wake_pin_p02 <= ~p[1];
        hit = c[3] && ((c[1:0] == 2'h1) ? !p[1] : (c[1:0] == 2'h2) ? 1 : p[1]);
        cyc(4);
        chk("reset", hit && !v[0], n_rst);
        chk("resume", hit && v[0], n_res);
        chk("clear", hit && v[0], n_clr);
        rd(SWC_SYS_STATE_ADDR, 8'(hit << 3));
        rd(SWC_WAKE_FLAG_ADDR, 8'(hit << (p[0] ? 2 : 1)));
      end
    end
    // Pins toggling while awake must not wake anything
    @(posedge clock) sleeping <= 1'b0;
    // Drop the counts left by the last sleeping pin case
    @(negedge clock) {n_res, n_rst, n_clr} = '0;
    repeat (20) @(posedge clock) {wake_pin_p03, wake_pin_p02} <= 2'(rnd());
    cyc(3);
    chk("awake", 0, n_rst + n_res);
    $display("Test pins done");
    for (int e = 0; e < 2; e++) begin
      wr(SWC_IO_CTL_ADDR, 8'(e << 2));
      arm(1'b0, 1'b0);
      @(posedge clock) energy_pulse_output <= 1'b1;
      @(posedge clock) energy_pulse_output <= 1'b0;
      cyc(3);
      chk("pulse reset", 0, n_rst);
      chk("pulse resume", e, n_res);
      chk("pulse clear", 0, n_clr);
      rd(SWC_SYS_STATE_ADDR, 8'(e << 2));
      rd(SWC_WAKE_FLAG_ADDR, 8'(e << 3));
    end
    $display("Test pulse done");
    wr(SWC_IO_CTL_ADDR, 8'h00);
    for (int k = 0; k < 11; k++) begin
      v = (k < 8) ? 8'h00 : {2'h1, (k == 8) ? 6'h00 : (k == 9) ? 6'h01 : 6'h3f};
      wr(SWC_RTC_IV_ADDR, (k < 8) ? 8'(k) : 8'h07);
      wr(SWC_SEC_IV_ADDR, v);
      lt = lim((k < 8) ? 8'(k) : 8'h07, v);
      if (lt > 2000) continue;
      arm(1'b0, 1'b0);
      repeat (lt - 1) tick();
      cyc(4);
      chk("rtc early", 0, n_res);
      tick();
      cyc(4);
      chk("rtc wake", 1, n_res);
      rd(SWC_SYS_STATE_ADDR, 8'h04);
      rd(SWC_WAKE_FLAG_ADDR, 8'h00);
    end
    $display("Test rtc done");
    end_of_test();
  end
endmodule : swc_wake_ctrl_test
`default_nettype wire
